// *** hdl/coef_swap_defines.svh ***
// Constants for the coefficient buffer swap and routing register bank
// Notes on behaviour
// - Two coefficient buffers, 256 words, 30 per page
// - Four bytes per word, MSB first, reserved last
// - Buffer A pages 44-52, buffer B 62-70
// - Instruction memory 1024 words from page 152
// - Mute bit 4 ramps channel B down/up
// - Mute bit 0 ramps channel A down/up
// - Bits 5:4 select channel B source
// - Bits 1:0 select channel A source
// - Powered down: host both buffers, DSP none
// - Powered up: DSP active, host other buffer
// - Active buffer indicator bit is read-only
// - Host requests swap; device clears when done
`ifndef COEF_SWAP_DEFINES_SVH
`define COEF_SWAP_DEFINES_SVH
`define CTRL_PAGE 8'h00
`define MUTE_REG 7'h03
`define ROUTE_REG 7'h2a
`define COEF_A_PAGE 8'h2c
`define COEF_A_LAST_PAGE 8'h34
`define COEF_B_PAGE 8'h3e
`define COEF_B_LAST_PAGE 8'h46
`define BUF_CTRL_REG 7'h01
`define INSTR_PAGE 8'h98
`define INSTR_LAST_PAGE 8'hba
`define FIRST_WORD_REG 7'h08
`define WORDS_PER_PAGE 11'h01e
`define COEF_DEPTH 11'h100
`define INSTR_DEPTH 11'h400
`define SWAP_BIT 0
`define ACTIVE_BIT 1
`define MODE_BIT_LO 2
`define MODE_BIT_HI 3
`define MUTE_A_BIT 0
`define MUTE_B_BIT 4
`define MUTE_RESET 8'h00
`define ROUTE_RESET 8'h11
`define GAIN_FULL 8'hff
`define GAIN_STEP 8'h08
`define ROUTE_ZERO 2'h0
`define ROUTE_OWN 2'h1
`define ROUTE_CROSS 2'h2
`endif

// *** hdl/coef_swap_pkg.sv ***
// Types for the coefficient buffer swap and routing register bank
package coef_swap_pkg;
  typedef enum logic [1:0] {
    SWAP_IDLE = 2'b01,
    SWAP_WAIT = 2'b10
  } swap_state_type;
  typedef logic [23:0] word_type;
endpackage : coef_swap_pkg

// *** hdl/coef_buffer_swap_and_routing.sv ***
// Paged register bank with double-buffered coefficients and routing
`timescale 1ns/10ps
`include "coef_swap_defines.svh"
module coef_buffer_swap_and_routing import coef_swap_pkg::*; (
  input wire logic sys_clk, // 250 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input wire logic [7:0] page, // Host register page
  input wire logic [6:0] reg_addr, // Host register within page
  input wire logic wr_en, // Host write strobe
  input wire logic rd_en, // Host read strobe
  input wire logic [7:0] wdata, // Host write byte
  output logic [7:0] rdata, // Host read byte
  output logic rd_valid, // Read data valid pulse
  input wire logic power_up, // High while device is powered up
  input wire logic frame_strobe, // Audio frame boundary pulse
  input wire logic [7:0] dsp_coef_idx, // Coefficient index from DSP
  input wire logic [9:0] dsp_instr_idx, // Instruction index from DSP
  output logic [23:0] dsp_coef, // Coefficient from active buffer
  output logic [23:0] dsp_instr, // Instruction word
  output logic active_buffer, // 0 = buffer A serves the DSP
  output logic [1:0] adaptive_mode, // Mode bits of buffer control
  input wire logic [23:0] ch_a_data, // Channel A sample
  input wire logic [23:0] ch_b_data, // Channel B sample
  output logic [23:0] out_a, // Routed channel A
  output logic [23:0] out_b, // Routed channel B
  output logic [7:0] gain_a, // Channel A volume ramp
  output logic [7:0] gain_b // Channel B volume ramp
);
  word_type coef_a_reg [256];
  word_type coef_a_next [256];
  word_type coef_b_reg [256];
  word_type coef_b_next [256];
  word_type instr_reg [1024];
  word_type instr_next [1024];
  swap_state_type swap_reg, swap_next;
  logic active_reg, active_next;
  logic [1:0] mode_reg, mode_next;
  logic [7:0] mute_reg, mute_next, route_reg, route_next;
  logic [7:0] gain_a_reg, gain_a_next, gain_b_reg, gain_b_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rd_valid_reg;
  logic [23:0] out_a_reg, out_a_next, out_b_reg, out_b_next;
  logic [23:0] dsp_coef_reg, dsp_coef_next, dsp_instr_reg;
  logic hit_a, hit_b, hit_i, hit_mute, hit_route, hit_ctrl;
  logic host_a_ok, host_b_ok, swap_set;
  logic [7:0] page_off;
  logic [10:0] word_idx;
  logic [1:0] lane;
  word_type sel_word;

  // Address decode: page offset times 30 plus word within page
  always_comb begin
    hit_a = 1'b0;
    hit_b = 1'b0;
    hit_i = 1'b0;
    page_off = 8'h00;
    lane = reg_addr[1:0];
    word_idx = 11'h000;
    hit_mute = (page == `CTRL_PAGE) && (reg_addr == `MUTE_REG);
    hit_route = (page == `CTRL_PAGE) && (reg_addr == `ROUTE_REG);
    hit_ctrl = (page == `COEF_A_PAGE) && (reg_addr == `BUF_CTRL_REG);
    if (page >= `COEF_A_PAGE && page <= `COEF_A_LAST_PAGE) begin
      page_off = page - `COEF_A_PAGE;
      hit_a = 1'b1;
    end else if (page >= `COEF_B_PAGE && page <= `COEF_B_LAST_PAGE) begin
      page_off = page - `COEF_B_PAGE;
      hit_b = 1'b1;
    // Upper bound keeps the 11-bit word index from wrapping
    end else if (page >= `INSTR_PAGE
      && page <= `INSTR_LAST_PAGE) begin
      page_off = page - `INSTR_PAGE;
      hit_i = 1'b1;
    end
    word_idx = {3'h0, page_off} * `WORDS_PER_PAGE
      + {6'h00, reg_addr[6:2]} - 11'h002;
    if (reg_addr < `FIRST_WORD_REG) begin
      hit_a = 1'b0;
      hit_b = 1'b0;
      hit_i = 1'b0;
    end
    if (word_idx >= `COEF_DEPTH) begin
      hit_a = 1'b0;
      hit_b = 1'b0;
    end
    if (word_idx >= `INSTR_DEPTH) begin
      hit_i = 1'b0;
    end
  end

  // Host reaches only the update buffer while powered up
  assign host_a_ok = !power_up || active_reg;
  assign host_b_ok = !power_up || !active_reg;

  // Byte writes into the word stores, MSB at lane 0, lane 3 dropped
  always_comb begin
    coef_a_next = coef_a_reg;
    coef_b_next = coef_b_reg;
    instr_next = instr_reg;
    if (wr_en && lane != 2'h3) begin
      if (hit_a && host_a_ok) begin
        coef_a_next[word_idx[7:0]][(5'd23 - 5'(lane) * 5'd8) -: 8] = wdata;
      end else if (hit_b && host_b_ok) begin
        coef_b_next[word_idx[7:0]][(5'd23 - 5'(lane) * 5'd8) -: 8] = wdata;
      end else if (hit_i) begin
        instr_next[word_idx[9:0]][(5'd23 - 5'(lane) * 5'd8) -: 8] = wdata;
      end
    end
  end

  // Control registers, swap handshake and host read path
  always_comb begin
    swap_next = swap_reg;
    active_next = active_reg;
    mode_next = mode_reg;
    mute_next = mute_reg;
    route_next = route_reg;
    rdata_next = rdata_reg;
    sel_word = 24'h000000;
    swap_set = wr_en && hit_ctrl && wdata[`SWAP_BIT];
    // Swap at a frame edge, or at once while powered down, so no frame mixes both buffers
    case (swap_reg)
      SWAP_IDLE: begin
        if (swap_set) begin
          swap_next = SWAP_WAIT;
        end
      end
      SWAP_WAIT: begin
        if (frame_strobe || !power_up) begin
          active_next = !active_reg;
          swap_next = swap_set ? SWAP_WAIT : SWAP_IDLE;
        end
      end
      default: swap_next = SWAP_IDLE;
    endcase
    if (wr_en && hit_ctrl) begin
      mode_next = wdata[`MODE_BIT_HI:`MODE_BIT_LO];
    end else if (wr_en && hit_mute) begin
      mute_next = wdata;
    end else if (wr_en && hit_route) begin
      route_next = wdata;
    end
    if (hit_a && host_a_ok) begin
      sel_word = coef_a_reg[word_idx[7:0]];
    end else if (hit_b && host_b_ok) begin
      sel_word = coef_b_reg[word_idx[7:0]];
    end else if (hit_i) begin
      sel_word = instr_reg[word_idx[9:0]];
    end
    if (rd_en) begin
      if (hit_ctrl) begin
        rdata_next = {4'h0, mode_reg, active_reg, swap_reg == SWAP_WAIT};
      end else if (hit_mute) begin
        rdata_next = mute_reg;
      end else if (hit_route) begin
        rdata_next = route_reg;
      end else if (lane == 2'h3) begin
        rdata_next = 8'h00; // Reserved lane reads zero
      end else begin
        rdata_next = sel_word[(5'd23 - 5'(lane) * 5'd8) -: 8];
      end
    end
  end

  // Soft mute ramps step once per frame; routing muxes per channel
  always_comb begin
    gain_a_next = gain_a_reg;
    gain_b_next = gain_b_reg;
    if (frame_strobe) begin
      if (mute_reg[`MUTE_A_BIT]) begin
        gain_a_next = (gain_a_reg > `GAIN_STEP) ?
          gain_a_reg - `GAIN_STEP : 8'h00;
      end else begin
        gain_a_next = (gain_a_reg < `GAIN_FULL - `GAIN_STEP) ?
          gain_a_reg + `GAIN_STEP : `GAIN_FULL;
      end
      if (mute_reg[`MUTE_B_BIT]) begin
        gain_b_next = (gain_b_reg > `GAIN_STEP) ?
          gain_b_reg - `GAIN_STEP : 8'h00;
      end else begin
        gain_b_next = (gain_b_reg < `GAIN_FULL - `GAIN_STEP) ?
          gain_b_reg + `GAIN_STEP : `GAIN_FULL;
      end
    end
    // Reserved code 11 falls to zero data
    case (route_reg[1:0])
      `ROUTE_OWN: out_a_next = ch_a_data;
      `ROUTE_CROSS: out_a_next = ch_b_data;
      default: out_a_next = 24'h000000;
    endcase
    case (route_reg[5:4])
      `ROUTE_OWN: out_b_next = ch_b_data;
      `ROUTE_CROSS: out_b_next = ch_a_data;
      default: out_b_next = 24'h000000;
    endcase
    // DSP sees zero coefficients while powered down
    if (!power_up) begin
      dsp_coef_next = 24'h000000;
    end else if (active_reg) begin
      dsp_coef_next = coef_b_reg[dsp_coef_idx];
    end else begin
      dsp_coef_next = coef_a_reg[dsp_coef_idx];
    end
  end

  // Register all state; ce low freezes everything
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coef_a_reg <= '{default: 24'h000000};
      coef_b_reg <= '{default: 24'h000000};
      instr_reg <= '{default: 24'h000000};
      swap_reg <= SWAP_IDLE;
      active_reg <= 1'b0;
      mode_reg <= 2'h0;
      mute_reg <= `MUTE_RESET;
      route_reg <= `ROUTE_RESET;
      gain_a_reg <= `GAIN_FULL;
      gain_b_reg <= `GAIN_FULL;
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      out_a_reg <= 24'h000000;
      out_b_reg <= 24'h000000;
      dsp_coef_reg <= 24'h000000;
      dsp_instr_reg <= 24'h000000;
    end else if (ce) begin
      coef_a_reg <= coef_a_next;
      coef_b_reg <= coef_b_next;
      instr_reg <= instr_next;
      swap_reg <= swap_next;
      active_reg <= active_next;
      mode_reg <= mode_next;
      mute_reg <= mute_next;
      route_reg <= route_next;
      gain_a_reg <= gain_a_next;
      gain_b_reg <= gain_b_next;
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_en;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
      dsp_coef_reg <= dsp_coef_next;
      dsp_instr_reg <= instr_reg[dsp_instr_idx];
    end
  end

  assign rdata = rdata_reg;
  assign rd_valid = rd_valid_reg;
  assign dsp_coef = dsp_coef_reg;
  assign dsp_instr = dsp_instr_reg;
  assign active_buffer = active_reg;
  assign adaptive_mode = mode_reg;
  assign out_a = out_a_reg;
  assign out_b = out_b_reg;
  assign gain_a = gain_a_reg;
  assign gain_b = gain_b_reg;

  property p_swap_at_frame;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && power_up && !frame_strobe |=> $stable(active_reg);
  endproperty
  a_swap_at_frame: assert property (p_swap_at_frame)
    else $error("Active buffer changed off a frame edge");

  property p_swap_done;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && swap_reg == SWAP_WAIT && frame_strobe && !swap_set
      |=> swap_reg == SWAP_IDLE && active_reg != $past(active_reg);
  endproperty
  a_swap_done: assert property (p_swap_done)
    else $error("Swap request not completed and cleared");

  property p_active_write_blocked;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && wr_en && hit_a && power_up && !active_reg
      |=> coef_a_reg[$past(word_idx[7:0])]
        == $past(coef_a_reg[word_idx[7:0]]);
  endproperty
  a_active_write_blocked: assert property (p_active_write_blocked)
    else $error("Write reached the active buffer");

  property p_route_a;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && route_reg[1:0] == `ROUTE_CROSS |=> out_a_reg == $past(ch_b_data);
  endproperty
  a_route_a: assert property (p_route_a)
    else $error("Channel A cross route wrong");

  property p_route_b_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && route_reg[5:4] == `ROUTE_ZERO |=> out_b_reg == 24'h000000;
  endproperty
  a_route_b_zero: assert property (p_route_b_zero)
    else $error("Channel B zero route not zero");

  property p_mute_a_down;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && frame_strobe && mute_reg[`MUTE_A_BIT] && gain_a_reg != 8'h00
      |=> gain_a_reg < $past(gain_a_reg);
  endproperty
  a_mute_a_down: assert property (p_mute_a_down)
    else $error("Channel A gain did not ramp down");

  property p_mute_b_up;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && frame_strobe && !mute_reg[`MUTE_B_BIT] && gain_b_reg != `GAIN_FULL
      |=> gain_b_reg > $past(gain_b_reg);
  endproperty
  a_mute_b_up: assert property (p_mute_b_up)
    else $error("Channel B gain did not ramp up");

  property p_dsp_blank_down;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && !power_up |=> dsp_coef_reg == 24'h000000;
  endproperty
  a_dsp_blank_down: assert property (p_dsp_blank_down)
    else $error("DSP read a buffer while powered down");

  property p_read_valid;
    @(posedge sys_clk) disable iff (!rst_n)
    ce && rd_en && hit_ctrl
      |=> rd_valid_reg && rdata_reg[1] == $past(active_reg);
  endproperty
  a_read_valid: assert property (p_read_valid)
    else $error("Indicator read back wrong");
endmodule : coef_buffer_swap_and_routing

// *** test/reg_host_model.sv ***
// Register host model for the paged byte port
`timescale 1ns/10ps
module reg_host_model (
  input wire logic sys_clk, // Device clock
  output logic [7:0] page, // Register page
  output logic [6:0] reg_addr, // Register in page
  output logic wr_en, // Write strobe
  output logic rd_en, // Read strobe
  output logic [7:0] wdata, // Write byte
  input wire logic [7:0] rdata, // Read byte
  input wire logic rd_valid // Read valid pulse
);
  // Idle bus at time zero
  initial begin
    page = 8'h00;
    reg_addr = 7'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
  end
  // One byte write; data inverted once released, never left stale
  task wr(input logic [7:0] p, input logic [6:0] r, input logic [7:0] d);
    @(posedge sys_clk);
    page <= p;
    reg_addr <= r;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
    wdata <= ~d;
  endtask : wr
  // One byte read, data taken one cycle after the strobe
  task rd(input logic [7:0] p, input logic [6:0] r, output logic [7:0] d,
          output logic v);
    @(posedge sys_clk);
    page <= p;
    reg_addr <= r;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
    v = rd_valid;
  endtask : rd
  // Word as three lanes, high byte first, reserved lane untouched
  task wr_word(input logic [7:0] p, input logic [6:0] r,
               input logic [23:0] w);
    wr(p, r, w[23:16]);
    wr(p, r + 7'h01, w[15:8]);
    wr(p, r + 7'h02, w[7:0]);
  endtask : wr_word
endmodule : reg_host_model

// *** test/tb_top.sv ***
// Self-checking bench for the coefficient swap register bank
`timescale 1ns/10ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] page;
  logic [6:0] reg_addr;
  logic wr_en, rd_en, rd_valid, active_buffer;
  logic [7:0] wdata, rdata, gain_a, gain_b;
  logic power_up = 1'b0;
  logic ce = 1'b1;
  logic frame_strobe = 1'b0;
  logic [7:0] dsp_coef_idx = 8'hff;
  logic [9:0] dsp_instr_idx = 10'h000;
  logic [23:0] dsp_coef, dsp_instr, out_a, out_b;
  logic [1:0] adaptive_mode;
  logic [23:0] ch_a_data = 24'h0a0a0a;
  logic [23:0] ch_b_data = 24'h0b0b0b;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] codes [3] = '{8'h00, 8'h22, 8'h11};
  logic [23:0] exp_a [3] = '{24'h0, 24'h0b0b0b, 24'h0a0a0a};
  logic [23:0] exp_b [3] = '{24'h0, 24'h0a0a0a, 24'h0b0b0b};

  always #2 sys_clk = ~sys_clk;

  coef_buffer_swap_and_routing dut (
    .sys_clk, .rst_n, .ce, .page, .reg_addr, .wr_en, .rd_en,
    .wdata, .rdata, .rd_valid, .power_up, .frame_strobe, .dsp_coef_idx,
    .dsp_instr_idx, .dsp_coef, .dsp_instr, .active_buffer,
    .adaptive_mode, .ch_a_data, .ch_b_data, .out_a, .out_b, .gain_a,
    .gain_b
  );
  reg_host_model host (
    .sys_clk, .page, .reg_addr, .wr_en, .rd_en, .wdata, .rdata,
    .rd_valid
  );

  // Compare and count
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask : chk
  // Read one byte; valid pulse folded into the compare
  task rc(input string n, input logic [7:0] p, input logic [6:0] r,
          input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(p, r, d, v);
    chk(n, {15'h0, 1'b1, e}, {15'h0, v, d});
  endtask : rc
  // Let registered outputs land
  task settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle
  // One audio frame boundary pulse
  task frame();
    @(posedge sys_clk);
    frame_strobe <= 1'b1;
    @(posedge sys_clk);
    frame_strobe <= 1'b0;
    #1;
  endtask : frame
  task print_verdict();
    $display("checks %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the hundred-odd cycles used
  initial begin
    #200000;
    bad_count++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rc("mute_rst", 8'h00, 7'h03, 8'h00);
    rc("route_rst", 8'h00, 7'h2a, 8'h11);
    rc("bufctl_rst", 8'h2c, 7'h01, 8'h00);
    chk("gains", {8'h0, 16'hffff}, {8'h0, gain_a, gain_b});
    host.wr(8'h00, 7'h03, 8'h11);
    // Every legal route code; zero code first, reset code last
    for (int i = 0; i < 3; i++) begin
      host.wr(8'h00, 7'h2a, codes[i]);
      settle();
      chk("out_a", exp_a[i], out_a);
      chk("out_b", exp_b[i], out_b);
    end
    // Powered down: host reaches both buffers, DSP sees zero
    host.wr_word(8'h34, 7'h44, 24'h123456);
    host.wr(8'h34, 7'h47, 8'h77);
    host.wr_word(8'h3e, 7'h08, 24'habcdef);
    rc("a_hi", 8'h34, 7'h44, 8'h12);
    rc("a_lo", 8'h34, 7'h46, 8'h56);
    rc("a_rsv", 8'h34, 7'h47, 8'h00);
    rc("b_hi", 8'h3e, 7'h08, 8'hab);
    chk("dsp_off", 24'h0, dsp_coef);
    host.wr_word(8'h99, 7'h08, 24'h3c5a69);
    @(posedge sys_clk);
    dsp_instr_idx <= 10'h01e;
    settle();
    chk("instr", 24'h3c5a69, dsp_instr);
    host.wr(8'h02, 7'h08, 8'h55);
    rc("rsv_page", 8'h02, 7'h08, 8'h00);
    // Adaptive mode, wake, unmute
    host.wr(8'h2c, 7'h01, 8'h0c);
    settle();
    chk("mode", 24'h3, {22'h0, adaptive_mode});
    @(posedge sys_clk);
    power_up <= 1'b1;
    host.wr(8'h00, 7'h03, 8'h00);
    settle();
    chk("dsp_a", 24'h123456, dsp_coef);
    rc("a_locked", 8'h34, 7'h44, 8'h00);
    host.wr(8'h34, 7'h44, 8'h99);
    rc("b_open", 8'h3e, 7'h08, 8'hab);
    // Swap request; indicator bit write must not stick
    host.wr(8'h2c, 7'h01, 8'h0f);
    rc("pending", 8'h2c, 7'h01, 8'h0d);
    chk("no_swap", 24'h0, {23'h0, active_buffer});
    @(posedge sys_clk);
    dsp_coef_idx <= 8'h00;
    frame();
    chk("swapped", 24'h1, {23'h0, active_buffer});
    rc("done", 8'h2c, 7'h01, 8'h0e);
    settle();
    chk("dsp_b", 24'habcdef, dsp_coef);
    rc("a_kept", 8'h34, 7'h44, 8'h12);
    // Soft mute per channel, one ramp step per frame
    host.wr(8'h00, 7'h03, 8'h01);
    frame();
    chk("mute_a", {8'h0, 16'hf7ff}, {8'h0, gain_a, gain_b});
    host.wr(8'h00, 7'h03, 8'h10);
    frame();
    chk("mute_b", {8'h0, 16'hfff7}, {8'h0, gain_a, gain_b});
    host.wr(8'h00, 7'h03, 8'h00);
    frame();
    chk("unmute_b", {8'h0, 16'hffff}, {8'h0, gain_a, gain_b});
    // Clock enable low must freeze the ramp across a frame
    host.wr(8'h00, 7'h03, 8'h11);
    @(posedge sys_clk);
    ce <= 1'b0;
    frame();
    chk("ce_hold", {8'h0, 16'hffff}, {8'h0, gain_a, gain_b});
    @(posedge sys_clk);
    ce <= 1'b1;
    frame();
    chk("mute_ab", {8'h0, 16'hf7f7}, {8'h0, gain_a, gain_b});
    print_verdict();
  end
endmodule : tb_top
